//--- rtl/csr_pkg.sv
/*
  constants for the charger status register group: offsets, field
  positions, codes, reset values and the die temperature threshold base and step.
  assumes an 8-bit internal register port and a single 100 MHz clock.
*/
// Function
// - input supply state bits 7:6: 00 uvlo, 01 low margin, 10 ovp, 11 good
// - state 11 only when above uvlo, margin met and below ovp together
// - bit 4 of first register is set while die temp exceeds threshold
// - battery condition bits 6:4, reset 111, codes passed from charger
// - charge phase bits 2:0, reset 000, codes passed from charger
// - bit 7 of third register is 0 exactly when temperature zone is 000
// - temperature zone bits 6:4 encode nominal, cold, cool, warm, hot
// - bit 2 of third register shows die regulation active, resets 0
// - timeout code bits 1:0; any nonzero value means charging suspended
// - addresses 1ch to 1fh are reserved and read as zero
// - threshold code picks 80 c to 115 c in 5 c steps
// - charger healthy is 0 for cold, hot or nonzero timeout, else 1
package csr_pkg;

  localparam logic [7:0] CSR_ADDR_INPUT_THERMAL = 8'h19;
  localparam logic [7:0] CSR_ADDR_BATTERY_PHASE = 8'h1a;
  localparam logic [7:0] CSR_ADDR_TEMP_TIMER    = 8'h1b;
  localparam logic [7:0] CSR_ADDR_RSVD_FIRST    = 8'h1c;
  localparam logic [7:0] CSR_ADDR_RSVD_LAST     = 8'h1f;

  localparam int CSR_POS_SUPPLY_STATE = 6;
  localparam int CSR_POS_DIE_REG_FLAG = 4;
  localparam int CSR_POS_BATT_COND    = 4;
  localparam int CSR_POS_PHASE        = 0;
  localparam int CSR_POS_TEMP_ABN     = 7;
  localparam int CSR_POS_TEMP_ZONE    = 4;
  localparam int CSR_POS_CHIP_TEMP    = 2;
  localparam int CSR_POS_TIMEOUT      = 0;

  localparam logic [1:0] CSR_SUPPLY_UVLO   = 2'h0;
  localparam logic [1:0] CSR_SUPPLY_MARGIN = 2'h1;
  localparam logic [1:0] CSR_SUPPLY_OVP    = 2'h2;
  localparam logic [1:0] CSR_SUPPLY_GOOD   = 2'h3;

  localparam logic [2:0] CSR_ZONE_NOMINAL = 3'h0;
  localparam logic [2:0] CSR_ZONE_COLD    = 3'h1;
  localparam logic [2:0] CSR_ZONE_HOT     = 3'h4;
  localparam logic [1:0] CSR_TIMEOUT_NONE = 2'h0;

  localparam logic [1:0] CSR_RST_SUPPLY_STATE = 2'h0;
  localparam logic [2:0] CSR_RST_BATT_COND    = 3'h7;
  localparam logic [2:0] CSR_RST_PHASE        = 3'h0;
  localparam logic [2:0] CSR_RST_TEMP_ZONE    = 3'h0;
  localparam logic [1:0] CSR_RST_TIMEOUT      = 2'h0;
  localparam logic [7:0] CSR_RST_DIE_TEMP     = 8'h00;

  localparam logic [7:0] CSR_THRESH_BASE_C = 8'h50;
  localparam logic [7:0] CSR_THRESH_STEP_C = 8'h05;

  localparam int CSR_SYNC_STAGES = 2;

endpackage

//--- rtl/csr_sync.sv
/*
  two-stage synchroniser for a bundle of level inputs from the analog side.
  assumes every bit is a slow level; a code may show a mixed value for one
  cycle while it changes.
*/
`timescale 1ns/1ps
module csr_sync
  import csr_pkg::*;
#(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             mclk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } csr_sync_s;

  csr_sync_s state_reg;
  csr_sync_s state_next;

  always_comb begin
    state_next        = state_reg;
    state_next.meta   = async_in;
    state_next.stable = state_reg.meta;
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_reg <= '{meta: RST_VAL, stable: RST_VAL};
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.stable;

endmodule

//--- rtl/csr_status_regs.sv
/*
  charger status register group: three read-only status registers at
  19h, 1ah and 1bh plus the reserved window 1ch to 1fh.
  assumes analog condition levels arrive unsynchronised, the threshold
  code comes from a control register on mclk_in, and the serial register
  port presents one read at a time with an 8-bit address.
*/
`timescale 1ns/1ps
module csr_status_regs
  import csr_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  input  wire logic       vin_above_uvlo_in,
  input  wire logic       supply_node_above_margin_in,
  input  wire logic       vin_above_ovp_in,
  input  wire logic       input_current_limited_in,
  input  wire logic [7:0] die_temp_c_in,
  input  wire logic [2:0] die_temp_threshold_sel_in,
  input  wire logic [2:0] battery_condition_code_in,
  input  wire logic [2:0] charge_phase_code_in,
  input  wire logic [2:0] battery_temp_zone_in,
  input  wire logic [1:0] charge_timeout_code_in,
  input  wire logic       rd_en_in,
  input  wire logic [7:0] rd_addr_in,
  output logic      [7:0] rd_data_out,
  output logic            rd_valid_out,
  output logic            rd_hit_out,
  output logic            input_supply_good_out,
  output logic            charger_healthy_out,
  output logic            die_regulation_flag_out,
  output logic            status_stale_out
);

  localparam int SYNC_W = 23;
  localparam logic [SYNC_W-1:0] SYNC_RST = {
    1'b0, 1'b0, 1'b0, 1'b0,
    CSR_RST_BATT_COND, CSR_RST_PHASE, CSR_RST_TEMP_ZONE,
    CSR_RST_TIMEOUT, CSR_RST_DIE_TEMP
  };

  typedef struct packed {
    logic [1:0] input_supply_state;
    logic       die_regulation_flag;
    logic [2:0] battery_condition_code;
    logic [2:0] charge_phase_code;
    logic [2:0] battery_temp_zone;
    logic [1:0] charge_timeout_code;
    logic       input_supply_good;
    logic       charger_healthy;
    logic       status_stale;
    logic [7:0] rd_data;
    logic       rd_valid;
    logic       rd_hit;
  } csr_status_s;

  csr_status_s      state_reg;
  csr_status_s      state_next;
  logic [SYNC_W-1:0] sync_bus;
  logic             s_uvlo_ok;
  logic             s_margin_ok;
  logic             s_ovp;
  logic             s_ilim;
  logic [2:0]       s_batt;
  logic [2:0]       s_phase;
  logic [2:0]       s_zone;
  logic [1:0]       s_timeout;
  logic [7:0]       s_die_temp;
  logic [7:0]       threshold_c;
  logic [7:0]       reg_input_thermal;
  logic [7:0]       reg_battery_phase;
  logic [7:0]       reg_temp_timer;

  csr_sync #(
    .WIDTH   (SYNC_W),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .mclk_in  (mclk_in),
    .rst_in   (rst_in),
    .async_in ({vin_above_uvlo_in, supply_node_above_margin_in,
                vin_above_ovp_in, input_current_limited_in,
                battery_condition_code_in, charge_phase_code_in,
                battery_temp_zone_in, charge_timeout_code_in,
                die_temp_c_in}),
    .sync_out (sync_bus)
  );

  assign {s_uvlo_ok, s_margin_ok, s_ovp, s_ilim, s_batt, s_phase,
          s_zone, s_timeout, s_die_temp} = sync_bus;

  // threshold 80 c plus 5 c per code step
  assign threshold_c = CSR_THRESH_BASE_C +
    8'(CSR_THRESH_STEP_C * {5'h00, die_temp_threshold_sel_in});

  // register images, reserved bits zero
  always_comb begin
    reg_input_thermal = 8'h00;
    reg_input_thermal[CSR_POS_SUPPLY_STATE +: 2] =
      state_reg.input_supply_state;
    reg_input_thermal[CSR_POS_DIE_REG_FLAG] = state_reg.die_regulation_flag;
    reg_battery_phase = 8'h00;
    reg_battery_phase[CSR_POS_BATT_COND +: 3] =
      state_reg.battery_condition_code;
    reg_battery_phase[CSR_POS_PHASE +: 3] = state_reg.charge_phase_code;
    reg_temp_timer = 8'h00;
    reg_temp_timer[CSR_POS_TEMP_ABN] =
      (state_reg.battery_temp_zone != CSR_ZONE_NOMINAL);
    reg_temp_timer[CSR_POS_TEMP_ZONE +: 3] =
      state_reg.battery_temp_zone;
    reg_temp_timer[CSR_POS_CHIP_TEMP] = state_reg.die_regulation_flag;
    reg_temp_timer[CSR_POS_TIMEOUT +: 2] =
      state_reg.charge_timeout_code;
  end

  always_comb begin
    state_next = state_reg;

    // input supply classification, uvlo first, then ovp, then margin
    if (!s_uvlo_ok) begin
      state_next.input_supply_state = CSR_SUPPLY_UVLO;
    end else if (s_ovp) begin
      state_next.input_supply_state = CSR_SUPPLY_OVP;
    end else if (!s_margin_ok) begin
      state_next.input_supply_state = CSR_SUPPLY_MARGIN;
    end else begin
      state_next.input_supply_state = CSR_SUPPLY_GOOD;
    end
    state_next.input_supply_good =
      s_uvlo_ok && s_margin_ok && !s_ovp;

    state_next.die_regulation_flag = (s_die_temp > threshold_c);
    state_next.battery_condition_code = s_batt;
    state_next.charge_phase_code      = s_phase;
    state_next.battery_temp_zone      = s_zone;
    state_next.charge_timeout_code    = s_timeout;

    state_next.charger_healthy =
      !((s_zone == CSR_ZONE_COLD) || (s_zone == CSR_ZONE_HOT) ||
        (s_timeout != CSR_TIMEOUT_NONE));

    // flag for the host that all three images are meaningless
    state_next.status_stale = s_ilim;

    // read port, one cycle latency
    state_next.rd_valid = rd_en_in;
    state_next.rd_hit   = 1'b0;
    state_next.rd_data  = 8'h00;
    if (rd_en_in) begin
      case (rd_addr_in)
        CSR_ADDR_INPUT_THERMAL: begin
          state_next.rd_hit  = 1'b1;
          state_next.rd_data = reg_input_thermal;
        end
        CSR_ADDR_BATTERY_PHASE: begin
          state_next.rd_hit  = 1'b1;
          state_next.rd_data = reg_battery_phase;
        end
        CSR_ADDR_TEMP_TIMER: begin
          state_next.rd_hit  = 1'b1;
          state_next.rd_data = reg_temp_timer;
        end
        default: begin
          // reserved window answers zero
          state_next.rd_hit = (rd_addr_in >= CSR_ADDR_RSVD_FIRST) &&
                              (rd_addr_in <= CSR_ADDR_RSVD_LAST);
          state_next.rd_data = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_reg.input_supply_state     <= CSR_RST_SUPPLY_STATE;
      state_reg.die_regulation_flag    <= 1'b0;
      state_reg.battery_condition_code <= CSR_RST_BATT_COND;
      state_reg.charge_phase_code      <= CSR_RST_PHASE;
      state_reg.battery_temp_zone      <= CSR_RST_TEMP_ZONE;
      state_reg.charge_timeout_code    <= CSR_RST_TIMEOUT;
      state_reg.input_supply_good      <= 1'b0;
      state_reg.charger_healthy        <= 1'b1;
      state_reg.status_stale           <= 1'b0;
      state_reg.rd_data                <= 8'h00;
      state_reg.rd_valid               <= 1'b0;
      state_reg.rd_hit                 <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rd_data_out             = state_reg.rd_data;
  assign rd_valid_out            = state_reg.rd_valid;
  assign rd_hit_out              = state_reg.rd_hit;
  assign input_supply_good_out   = state_reg.input_supply_good;
  assign charger_healthy_out     = state_reg.charger_healthy;
  assign die_regulation_flag_out = state_reg.die_regulation_flag;
  assign status_stale_out        = state_reg.status_stale;

endmodule

//--- verification/csr_status_checker.sv
/*
  checker for the charger status registers, watching top-level ports.
  assumes reads are one-cycle pulses answered one cycle later.
*/
`timescale 1ns/1ps
module csr_status_checker (
  input wire logic       mclk_in,
  input wire logic       rst_in,
  input wire logic       rd_en_in,
  input wire logic [7:0] rd_addr_in,
  input wire logic [7:0] rd_data_out,
  input wire logic       rd_valid_out,
  input wire logic       rd_hit_out,
  input wire logic       input_supply_good_out,
  input wire logic       die_regulation_flag_out,
  input wire logic       input_current_limited_in,
  input wire logic       status_stale_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  sequence s_answer;
    ##1 rd_valid_out;
  endsequence
  sequence s_flag_quiet;
    $stable(die_regulation_flag_out) [*3];
  endsequence
  sequence s_good_quiet;
    $stable(input_supply_good_out) [*3];
  endsequence
  a_read_answer: assert property (rd_en_in |-> s_answer)
    else $error("read not answered");
  a_valid_cause: assert property (rd_valid_out |-> $past(rd_en_in))
    else $error("answer without request");
  a_hit_range: assert property (rd_valid_out |-> rd_hit_out ==
    ($past(rd_addr_in) inside {[8'h19:8'h1f]})) else $error("bad hit");
  a_rsvd_zero: assert property (rd_valid_out &&
    $past(rd_addr_in) >= 8'h1c |-> rd_data_out == 8'h00)
    else $error("reserved address not zero");
  a_idle_zero: assert property (!rd_valid_out |-> rd_data_out == 8'h00)
    else $error("data outside answer");
  a_first_bits: assert property (rd_valid_out &&
    $past(rd_addr_in) == 8'h19 |-> rd_data_out[5] == 1'b0 &&
    rd_data_out[3:0] == 4'h0) else $error("first register spare bits");
  a_second_bits: assert property (rd_valid_out &&
    $past(rd_addr_in) == 8'h1a |-> !rd_data_out[7] && !rd_data_out[3])
    else $error("second register spare bits");
  a_zone_flag: assert property (rd_valid_out &&
    $past(rd_addr_in) == 8'h1b |-> !rd_data_out[3] &&
    rd_data_out[7] == (rd_data_out[6:4] != 3'h0))
    else $error("zone flag wrong");
  a_flag_agree: assert property (s_flag_quiet ##0 (rd_valid_out &&
    $past(rd_addr_in) == 8'h19) |-> rd_data_out[4] ==
    die_regulation_flag_out) else $error("regulation flag mismatch");
  a_good_agree: assert property (s_good_quiet ##0 (rd_valid_out &&
    $past(rd_addr_in) == 8'h19) |-> (rd_data_out[7:6] == 2'h3) ==
    input_supply_good_out) else $error("supply good mismatch");
  a_stale_follow: assert property ($rose(input_current_limited_in)
    |-> ##[1:4] status_stale_out) else $error("stale not raised");
endmodule

//--- verification/csr_host_model.sv
/*
  host reader model: issues one-cycle read pulses, collects the answer.
  assumes the status block answers in the cycle after the request edge.
*/
`timescale 1ns/1ps
module csr_host_model (
  input  wire logic       mclk_in,
  input  wire logic [7:0] rd_data_in,
  input  wire logic       rd_valid_in,
  input  wire logic       rd_hit_in,
  output logic            rd_en_out,
  output logic      [7:0] rd_addr_out
);
  initial begin
    rd_en_out = 1'b0;
    rd_addr_out = 8'h00;
  end
  // callers check supply good in t_reset, t_supply and t_codes, stale in t_codes and t_stale; t_reset reads while supply is not good
  // reserved addresses are read only to see them empty
  task automatic read(input logic [7:0] a, output logic [7:0] d,
                      output logic h);
    rd_en_out = 1'b1;
    rd_addr_out = a;
    @(posedge mclk_in);
    #1;
    // answer stands in the cycle after the request edge
    d = rd_valid_in ? rd_data_in : ~rd_data_in;
    h = rd_hit_in;
    rd_en_out = 1'b0;
    rd_addr_out = ~a;
    @(posedge mclk_in);
    #1;
  endtask
endmodule

//--- verification/testbench.sv
/*
  self-checking bench for the charger status registers.
  assumes the host model and the checker bound below.
*/
`timescale 1ns/1ps
module testbench;
  logic       mclk_in = 1'b0;
  logic       rst_in  = 1'b1;
  logic       uvlo    = 1'b0;
  logic       margin  = 1'b0;
  logic       ovp     = 1'b0;
  logic       ilim    = 1'b0;
  logic [7:0] temp    = 8'h00;
  logic [2:0] sel     = 3'h0;
  logic [2:0] cond    = 3'h7;
  logic [2:0] phase   = 3'h0;
  logic [2:0] zone    = 3'h0;
  logic [1:0] tmo     = 2'h0;
  logic       rd_en, rd_valid, rd_hit, good, healthy, flag, stale;
  logic [7:0] rd_addr, rd_data;
  int         bad_count = 0;
  int         cmp_count = 0;
  int         cycles    = 0;
  csr_status_regs uut (.mclk_in, .rst_in, .vin_above_uvlo_in(uvlo),
    .supply_node_above_margin_in(margin), .vin_above_ovp_in(ovp),
    .input_current_limited_in(ilim), .die_temp_c_in(temp),
    .die_temp_threshold_sel_in(sel), .battery_condition_code_in(cond),
    .charge_phase_code_in(phase), .battery_temp_zone_in(zone),
    .charge_timeout_code_in(tmo), .rd_en_in(rd_en), .rd_addr_in(rd_addr),
    .rd_data_out(rd_data), .rd_valid_out(rd_valid), .rd_hit_out(rd_hit),
    .input_supply_good_out(good), .charger_healthy_out(healthy),
    .die_regulation_flag_out(flag), .status_stale_out(stale));
  csr_host_model host (.mclk_in, .rd_data_in(rd_data),
    .rd_valid_in(rd_valid), .rd_hit_in(rd_hit), .rd_en_out(rd_en),
    .rd_addr_out(rd_addr));
  task automatic test_done;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic eh);
    logic [7:0] d;
    logic       h;
    host.read(a, d, h);
    chk(d, e);
    chk({7'h00, h}, {7'h00, eh});
  endtask
  task automatic settle;
    repeat (4) @(posedge mclk_in);
    #1;
  endtask
  task automatic t_reset;
    rd(8'h19, 8'h00, 1'b1);
    rd(8'h1a, 8'h70, 1'b1);
    rd(8'h1b, 8'h00, 1'b1);
    chk({7'h00, healthy}, 8'h01);
    chk({7'h00, good}, 8'h00);
  endtask
  task automatic t_supply;
    logic [1:0] e;
    for (int i = 0; i < 8; i++) begin
      {uvlo, margin, ovp} = 3'(i);
      e = !uvlo ? 2'h0 : ovp ? 2'h2 : !margin ? 2'h1 : 2'h3;
      settle();
      rd(8'h19, {e, 6'h00}, 1'b1);
      chk({7'h00, good}, {7'h00, e == 2'h3});
    end
  endtask
  task automatic t_die;
    logic f;
    ovp = 1'b0;
    for (int i = 0; i < 16; i++) begin
      sel = 3'(i / 2);
      temp = 8'h50 + 8'(5 * (i / 2)) + 8'(i % 2);
      f = i[0];
      settle();
      rd(8'h19, {2'h3, 1'b0, f, 4'h0}, 1'b1);
      rd(8'h1b, {5'h00, f, 2'h0}, 1'b1);
      chk({7'h00, flag}, {7'h00, f});
    end
    temp = 8'h00;
  endtask
  task automatic t_codes;
    logic h;
    for (int i = 0; i < 8; i++) begin
      {cond, phase, zone} = {3{3'(i)}};
      tmo = 2'(i);
      h = !(zone == 3'h1 || zone == 3'h4 || tmo != 2'h0);
      settle();
      chk({7'h00, good}, 8'h01);
      chk({7'h00, stale}, 8'h00);
      rd(8'h1a, {1'b0, cond, 1'b0, phase}, 1'b1);
      rd(8'h1b, {zone != 3'h0, zone, 2'h0, tmo}, 1'b1);
      chk({7'h00, healthy}, {7'h00, h});
    end
  endtask
  task automatic t_rsvd;
    for (int a = 8'h1c; a < 8'h20; a++) begin
      rd(8'(a), 8'h00, 1'b1);
    end
    rd(8'h18, 8'h00, 1'b0);
    rd(8'h20, 8'h00, 1'b0);
  endtask
  task automatic t_stale;
    ilim = 1'b1;
    settle();
    chk({7'h00, stale}, 8'h01);
    ilim = 1'b0;
    settle();
    chk({7'h00, stale}, 8'h00);
  endtask
  initial begin
    forever #5 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      test_done();
    end
  end
  initial begin
    repeat (6) @(posedge mclk_in);
    #1;
    rst_in = 1'b0;
    t_reset();
    t_supply();
    t_die();
    t_codes();
    t_rsvd();
    t_stale();
    test_done();
  end
endmodule
bind csr_status_regs csr_status_checker chk_i (.mclk_in, .rst_in,
  .rd_en_in, .rd_addr_in, .rd_data_out, .rd_valid_out, .rd_hit_out,
  .input_supply_good_out, .die_regulation_flag_out,
  .input_current_limited_in, .status_stale_out);
